// ===== floppy_result_status.sv
// Result status bytes two and three of a diskette controller.
// Assumes the command engine pulses its events on clk and reads the FIFO byte.
// What this block does
// - Bit seven of both bytes reads zero
// - Byte three bits five, three read one
// - Deleted data mark in a read command sets byte two bit six
// - Data field CRC error sets bit five
// - Wrong track sets bit four, byte-one bit two
// - Scan equal hit sets bit three
// - Scan not satisfied sets bit two
// - Track FF mismatch: bit one, byte-one bit two
// - Bit zero: one data mark, zero ID
// - Either missing mark sets byte-zero bit zero
// - Write protect pin mirrored in bit six
// - Track zero pin mirrored in bit four
// - Head one select mirrored in bit two
// - Selected drive in bits one, zero
// - Bytes delivered through data FIFO register
// - Drive select is binary index
`timescale 1ns/1ps
`default_nettype none
module floppy_result_status
  import result_status_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       softReset,
  // Command engine events
  input  wire logic       cmdStart,
  input  wire logic       readCmd,
  input  wire logic       deletedMarkSeen,
  input  wire logic       dataCrcErr,
  input  wire logic       idTrackValid,
  input  wire logic [7:0] mediaTrack,
  input  wire logic [7:0] cmdTrack,
  input  wire logic       scanCmd,
  input  wire logic       scanEqualHit,
  input  wire logic       scanNotSat,
  input  wire logic       missDataMark,
  input  wire logic       missIdMark,
  // Drive selection and pins
  input  wire logic [1:0] driveSel,
  input  wire logic       writeProtect_n,
  input  wire logic       trackZero_n,
  input  wire logic       headOneSel_n,
  input  wire logic       diskInPlace_n,
  input  wire logic       highDensityInd,
  // Result phase FIFO read
  input  wire logic       resultRead,
  input  wire logic [1:0] resultSel,
  output var  logic [7:0] fifoData,
  // Flags into bytes zero and one
  output var  logic       missMarkFlag,
  output var  logic       noDataFlag,
  // Registered status
  output var  logic [7:0] resultStatusTwo,
  output var  logic [7:0] resultStatusThree,
  output var  logic       mediaPresent,
  output var  logic       highDensity
);

  logic [7:0] two_q;
  logic [7:0] two_d;
  logic       missMark_q;
  logic       noData_q;
  logic [4:0] pinSync;
  logic [7:0] three_q;
  logic [7:0] three_d;
  logic       badTrack;
  logic       wrongTrack;

  // ********************************
  // Pin synchronisers
  // ********************************
  drive_line_sync #(.W(5), .RST(PIN_IDLE)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .async ({highDensityInd, diskInPlace_n, headOneSel_n, trackZero_n, writeProtect_n}),
    .sync  (pinSync)
  );

  // ********************************
  // Track checks
  // ********************************
  always_comb
  begin
    badTrack   = idTrackValid && (mediaTrack == BAD_TRACK_NUM)
                 && (cmdTrack != BAD_TRACK_NUM);
    wrongTrack = idTrackValid && (mediaTrack != cmdTrack) && !badTrack;
  end

  // ********************************
  // Byte two flags
  // ********************************
  always_comb
  begin
    two_d = cmdStart ? STATUS_RESET : two_q;
    if (readCmd && deletedMarkSeen)
      two_d[S2_CTRL_MARK] = 1'b1;
    if (dataCrcErr)
      two_d[S2_DATA_CRC] = 1'b1;
    if (wrongTrack)
      two_d[S2_WRONG_TRK] = 1'b1;
    if (scanCmd && scanEqualHit)
      two_d[S2_SCAN_EQ] = 1'b1;
    if (scanCmd && scanNotSat)
      two_d[S2_SCAN_NSAT] = 1'b1;
    if (badTrack)
      two_d[S2_BAD_TRK] = 1'b1;
    if (missDataMark)
      two_d[S2_MISS_DAM] = 1'b1;
    else if (missIdMark)
      two_d[S2_MISS_DAM] = 1'b0;
    two_d[S2_RSVD7] = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      two_q <= STATUS_RESET;
    else if (softReset)
      two_q <= STATUS_RESET;
    else
      two_q <= two_d;
  end

  // ********************************
  // Side flags for bytes zero, one
  // ********************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      missMark_q <= 1'b0;
      noData_q   <= 1'b0;
    end
    else if (softReset)
    begin
      missMark_q <= 1'b0;
      noData_q   <= 1'b0;
    end
    else
    begin
      if (missDataMark || missIdMark)
        missMark_q <= 1'b1;
      else if (cmdStart)
        missMark_q <= 1'b0;
      if (wrongTrack || badTrack)
        noData_q <= 1'b1;
      else if (cmdStart)
        noData_q <= 1'b0;
    end
  end

  // ********************************
  // Byte three mirror
  // ********************************
  always_comb
  begin
    three_d            = 8'h00;
    three_d[S3_RSVD7]  = 1'b0;
    three_d[S3_WPROT]  = !pinSync[0];
    three_d[S3_ONE5]   = 1'b1;
    three_d[S3_TRK0]   = !pinSync[1];
    three_d[S3_ONE3]   = 1'b1;
    three_d[S3_HEAD1]  = !pinSync[2];
    three_d[S3_DRV_HI:S3_DRV_LO] = driveSel;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      three_q <= STATUS_RESET;
    else
      three_q <= three_d;
  end

  // ********************************
  // Presence lines, already gated by drive select
  // ********************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mediaPresent <= 1'b0;
      highDensity  <= 1'b0;
    end
    else
    begin
      mediaPresent <= !pinSync[3];
      highDensity  <= pinSync[4];
    end
  end

  // ********************************
  // Result FIFO byte
  // ********************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fifoData <= STATUS_RESET;
    else if (resultRead)
    begin
      case (result_sel_t'(resultSel))
        SelTwo:   fifoData <= two_q;
        SelThree: fifoData <= three_q;
        default:  fifoData <= STATUS_RESET;
      endcase
    end
  end

  always_comb
  begin
    resultStatusTwo   = two_q;
    resultStatusThree = three_q;
    missMarkFlag      = missMark_q;
    noDataFlag        = noData_q;
  end

endmodule
`default_nettype wire

// ===== result_status_pkg.sv
// Package: constants for the diskette result status bytes two and three.
// Assumes a single controller clock and a byte-wide result path.
package result_status_pkg;

  // ********************************
  // Bit positions, status byte two
  // ********************************
  localparam int S2_RSVD7      = 7;
  localparam int S2_CTRL_MARK  = 6;
  localparam int S2_DATA_CRC   = 5;
  localparam int S2_WRONG_TRK  = 4;
  localparam int S2_SCAN_EQ    = 3;
  localparam int S2_SCAN_NSAT  = 2;
  localparam int S2_BAD_TRK    = 1;
  localparam int S2_MISS_DAM   = 0;

  // ********************************
  // Bit positions, status byte three
  // ********************************
  localparam int S3_RSVD7      = 7;
  localparam int S3_WPROT      = 6;
  localparam int S3_ONE5       = 5;
  localparam int S3_TRK0       = 4;
  localparam int S3_ONE3       = 3;
  localparam int S3_HEAD1      = 2;
  localparam int S3_DRV_HI     = 1;
  localparam int S3_DRV_LO     = 0;

  // ********************************
  // Other status bytes touched here
  // ********************************
  localparam int S0_MISS_AM    = 0;
  localparam int S1_NO_DATA    = 2;

  // ********************************
  // Values
  // ********************************
  localparam logic [7:0] BAD_TRACK_NUM = 8'hff;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  // Idle pin levels: active-low lines high, density low
  localparam logic [4:0] PIN_IDLE      = 5'h0f;
  localparam logic [2:0] RESULT_LAST   = 3'h3;

  // Result byte order in the data FIFO
  typedef enum logic [1:0] {SelTwo, SelThree, SelNone} result_sel_t;

endpackage

// ===== drive_line_sync.sv
// Two-stage synchroniser for the drive status pins.
// Assumes pins are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module drive_line_sync #(
  parameter int           W   = 4,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Lines
  input  wire logic [W-1:0] async,
  output var  logic [W-1:0] sync
);

  logic [W-1:0] meta_q;

  // ********************************
  // Synchroniser
  // ********************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= RST;
      sync   <= RST;
    end
    else
    begin
      meta_q <= async;
      sync   <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ===== floppy_result_status_chk.sv
// Checker: result status relations seen at the top ports.
// Assumes one clock domain and binding onto floppy_result_status.
`timescale 1ns/1ps
`default_nettype none
module floppy_result_status_chk (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       softReset,
  // Command inputs
  input wire logic       readCmd,
  input wire logic       scanCmd,
  input wire logic       deletedMarkSeen,
  input wire logic       dataCrcErr,
  input wire logic       idTrackValid,
  input wire logic       scanEqualHit,
  input wire logic       scanNotSat,
  input wire logic       missDataMark,
  input wire logic [7:0] mediaTrack,
  input wire logic [7:0] cmdTrack,
  // Pins, selection, FIFO read
  input wire logic       writeProtect_n,
  input wire logic       trackZero_n,
  input wire logic       headOneSel_n,
  input wire logic [1:0] driveSel,
  input wire logic       resultRead,
  input wire logic [1:0] resultSel,
  // Outputs
  input wire logic       missMarkFlag,
  input wire logic       noDataFlag,
  input wire logic [7:0] fifoData,
  input wire logic [7:0] resultStatusTwo,
  input wire logic [7:0] resultStatusThree
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_fixed;
    rst_n && $past(rst_n) |-> {resultStatusTwo[7], resultStatusThree[7],
      resultStatusThree[5], resultStatusThree[3]} == 4'h3;
  endproperty
  a_fixed:
    assert property (p_fixed) else $error("fixed bits wrong");
  property p_del;
    deletedMarkSeen && readCmd && !softReset |=> resultStatusTwo[6];
  endproperty
  a_del:
    assert property (p_del) else $error("deleted mark flag missing");
  property p_crc;
    dataCrcErr && !softReset |=> resultStatusTwo[5];
  endproperty
  a_crc:
    assert property (p_crc) else $error("data crc flag missing");
  property p_wrong;
    idTrackValid && !softReset && mediaTrack != cmdTrack && mediaTrack != 8'hff
      |=> resultStatusTwo[4] && noDataFlag;
  endproperty
  a_wrong:
    assert property (p_wrong) else $error("wrong track flags missing");
  property p_equal;
    scanCmd && scanEqualHit && !softReset |=> resultStatusTwo[3];
  endproperty
  a_equal:
    assert property (p_equal) else $error("scan equal flag missing");
  property p_nsat;
    scanCmd && scanNotSat && !softReset |=> resultStatusTwo[2];
  endproperty
  a_nsat:
    assert property (p_nsat) else $error("scan not satisfied flag missing");
  property p_bad;
    idTrackValid && !softReset && mediaTrack == 8'hff && cmdTrack != 8'hff
      |=> resultStatusTwo[1] && noDataFlag;
  endproperty
  a_bad:
    assert property (p_bad) else $error("bad track flags missing");
  property p_miss;
    missDataMark && !softReset |=> resultStatusTwo[0] && missMarkFlag;
  endproperty
  a_miss:
    assert property (p_miss) else $error("missing data mark flags wrong");
  property p_pins;
    $stable({writeProtect_n, trackZero_n, headOneSel_n}) [*4] |-> {resultStatusThree[6],
      resultStatusThree[4], resultStatusThree[2]} == ~{writeProtect_n, trackZero_n, headOneSel_n};
  endproperty
  a_pins:
    assert property (p_pins) else $error("drive pin mirror wrong");
  property p_drv;
    rst_n && $past(rst_n) |-> resultStatusThree[1:0] == $past(driveSel);
  endproperty
  a_drv:
    assert property (p_drv) else $error("drive index wrong");
  property p_fifo;
    resultRead && resultSel == 2'h1 |=> fifoData == $past(resultStatusThree);
  endproperty
  a_fifo:
    assert property (p_fifo) else $error("fifo byte three wrong");
endmodule
bind floppy_result_status floppy_result_status_chk chk (.*);
`default_nettype wire

// ===== floppy_drive_model.sv
// Drive model: status pins of drive zero; disk-in-place and density are qualified by its select.
// Assumes the bench sets the mechanical states.
`timescale 1ns/1ps
`default_nettype none
module floppy_drive_model (
  // Select and states
  input  wire logic [1:0] driveSel,
  input  wire logic       diskIn,
  input  wire logic       wpOn,
  input  wire logic       trk0On,
  input  wire logic       headOn,
  // Pins
  output wire logic       writeProtect_n,
  output wire logic       trackZero_n,
  output wire logic       headOneSel_n,
  output wire logic       diskInPlace_n,
  output wire logic       highDensityInd
);
  localparam logic [1:0] MY_DRIVE = 2'h0;
  wire logic sel = driveSel == MY_DRIVE;
  assign diskInPlace_n  = !(sel && diskIn);
  assign highDensityInd = sel && diskIn;
  assign writeProtect_n = !wpOn;
  assign trackZero_n    = !trk0On;
  assign headOneSel_n   = !headOn;
endmodule
`default_nettype wire

// ===== tb_floppy_result_status.sv
// Testbench: status bytes, drive pin mirror and FIFO reads.
// Assumes the drive model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_floppy_result_status;
  logic clk = 1'b0, rst_n = 1'b0, softReset = 1'b0, readCmd = 1'b0, scanCmd = 1'b0;
  logic resultRead = 1'b0, diskIn = 1'b1, wpOn = 1'b0, trk0On = 1'b0, headOn = 1'b0;
  logic [1:0] driveSel = 2'h0, resultSel = 2'h0;
  logic [7:0] evt = 8'h00, mediaTrack = 8'h00, cmdTrack = 8'h00;
  logic [7:0] fifoData, resultStatusTwo, resultStatusThree;
  logic cmdStart, deletedMarkSeen, dataCrcErr, idTrackValid, scanEqualHit, scanNotSat;
  logic missDataMark, missIdMark, missMarkFlag, noDataFlag, mediaPresent, highDensity;
  logic writeProtect_n, trackZero_n, headOneSel_n, diskInPlace_n, highDensityInd;
  int n_mismatch = 0, tests_run = 0;
  assign {cmdStart, deletedMarkSeen, dataCrcErr, idTrackValid, scanEqualHit, scanNotSat,
    missDataMark, missIdMark} = evt;
  always #5 clk = ~clk;
  floppy_drive_model drive (.*);
  floppy_result_status dut (.*);
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task pulse(input logic [7:0] v);
    @(posedge clk) evt <= v;
    @(posedge clk) evt <= 8'h00;
  endtask
  task rd(input logic [1:0] s, input logic [7:0] e);
    @(posedge clk)
    begin
      resultRead <= 1'b1;
      resultSel <= s;
    end
    @(posedge clk) resultRead <= 1'b0;
    @(posedge clk) chk("fifo byte", e, fifoData);
  endtask
  task s_pins();
    {wpOn, trk0On, headOn} <= 3'h7;
    repeat (5) @(posedge clk);
    rd(2'h1, 8'h7c);
    chk("present", 8'h01, {7'h0, mediaPresent});
    chk("density", 8'h01, {7'h0, highDensity});
    {wpOn, trk0On, headOn, driveSel} <= 5'h03;
    repeat (5) @(posedge clk);
    rd(2'h1, 8'h2b);
    chk("present", 8'h00, {7'h0, mediaPresent});
    chk("density", 8'h00, {7'h0, highDensity});
    driveSel <= 2'h0;
  endtask
  task s_flags();
    readCmd <= 1'b1;
    pulse(8'h60);
    rd(2'h0, 8'h60);
    pulse(8'h80);
    rd(2'h0, 8'h00);
    readCmd <= 1'b0;
    scanCmd <= 1'b1;
    pulse(8'h4c);
    rd(2'h0, 8'h0c);
    pulse(8'h82);
    rd(2'h0, 8'h01);
    chk("miss mark", 8'h01, {7'h0, missMarkFlag});
    pulse(8'h01);
    rd(2'h0, 8'h00);
    chk("miss mark", 8'h01, {7'h0, missMarkFlag});
    pulse(8'h20);
    softReset <= 1'b1;
    @(posedge clk) softReset <= 1'b0;
    rd(2'h0, 8'h00);
    chk("miss mark", 8'h00, {7'h0, missMarkFlag});
    rd(2'h2, 8'h00);
  endtask
  task s_track(input logic [7:0] m, input logic [7:0] c, input logic [7:0] e);
    pulse(8'h80);
    {mediaTrack, cmdTrack} <= {m, c};
    pulse(8'h10);
    rd(2'h0, e);
    chk("no data", {7'h0, e != 8'h00}, {7'h0, noDataFlag});
  endtask
  task end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    s_pins();
    s_flags();
    s_track(8'h05, 8'h06, 8'h10);
    s_track(8'hff, 8'h03, 8'h02);
    s_track(8'hff, 8'hff, 8'h00);
    end_of_test();
  end
  initial
  begin
    #20us;
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
